/* File: rtl/adc_ctrl_cfg.svh */
// Purpose: Register offsets, field positions and reset values of the converter control block
// Assumes: 16-bit registers on a plain address/strobe port
// Notes:   Offsets are word indices on the local port
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

`define ADDR_W              4
`define DATA_W              16
`define NUM_INPUTS          22
`define RESULT_W            12

`define OFS_CONV_CTRL_LOW   4'h0
`define OFS_TRIG_LOW        4'h1
`define OFS_TRIG_HIGH       4'h2
`define OFS_CMP0_CTRL       4'h3
`define OFS_CMP0_LOW        4'h4
`define OFS_CMP0_HIGH       4'h5
`define OFS_CMP1_CTRL       4'h6
`define OFS_CMP1_LOW        4'h7
`define OFS_CMP1_HIGH       4'h8
`define OFS_IRQ_STATUS      4'h9
`define OFS_IRQ_MASK        4'ha

`define BIT_CONVERTER_ON    15
`define BIT_HALT_IN_IDLE    13
`define MASK_CTRL_LOW       16'ha000
`define MASK_TRIG_HIGH      16'h003f

`define BIT_COMPARE_ON      7
`define BIT_IRQ_ON_EVENT    6
`define BIT_EVENT_FLAG      5
`define CMP_COND_W          5
`define CMP_INPUT_LSB       8
`define CMP_INPUT_W         5
`define MASK_CMP_WRITE      16'h00df

`define RESET_REG           16'h0000
`define IRQ_W               2

`endif

/* File: rtl/adc_ctrl_pkg.sv */
// Purpose: Types of the converter control block
// Assumes: Widths from adc_ctrl_cfg.svh
// Notes:   State is one packed struct
`include "adc_ctrl_cfg.svh"
package adc_ctrl_pkg;

  typedef struct packed {
    logic [`CMP_INPUT_W-1:0] event_input_number;
    logic                    compare_unit_on;
    logic                    interrupt_on_event;
    logic                    event_flag;
    logic [`CMP_COND_W-1:0]  cond_enable;
    logic [`RESULT_W-1:0]    low_limit;
    logic [`RESULT_W-1:0]    high_limit;
  } comparator_type;

  typedef struct packed {
    logic                     converter_on;
    logic                     halt_in_idle;
    logic [`NUM_INPUTS-1:0]   level_trigger_select;
    comparator_type [1:0]     cmp;
    logic [`IRQ_W-1:0]        irq_status;
    logic [`IRQ_W-1:0]        irq_mask;
    logic [`DATA_W-1:0]       read_data;
  } state_type;

endpackage : adc_ctrl_pkg

/* File: rtl/adc_ctrl.sv */
// Purpose: Converter enable, idle stop, trigger mode and two result comparators
// Assumes: Results arrive as a one-cycle valid with input number, same clock
// Notes:   Register reads return data one cycle after the read strobe
`timescale 1ns/1ns
`include "adc_ctrl_cfg.svh"

// Operation
// R1 - The converter runs only while converter_on, bit 15 of the first control register, is set.
// R2 - Software finishes configuration before setting converter_on; changes while on are undefined.
// R3 - With halt_in_idle set the converter stops while the device is idle, otherwise it keeps going.
// R4 - Unimplemented bits of the first control register read zero; software writes zero to bits 6-3.
// R5 - Inputs 0 to 15 trigger on level when their low trigger-mode bit is 1 and on edge when 0.
// R6 - Inputs 16 to 21 use bits 5-0 of the high trigger-mode register; other bits read zero.
// R7 - Two independent comparators each have a control register and low and high limits.
// R8 - On an event the comparator stores the 5-bit input number in bits 12-8 of its control register.
// R9 - A comparator works only while compare_unit_on is set; clearing it also clears the event flag.
// R10 - With interrupt_on_event set each comparator event raises the converter interrupt. The code sets irq_status; irq follows only where irq_mask is set.
// R11 - The event flag in bit 5 is set by an event and cleared when software reads the input number.
// R12 - The window condition fires when the result is at least low and below high.
// R13 - The at-or-above-high condition fires when the result is at or above the high limit.
// R14 - The below-high condition fires when the result is strictly below the high limit.
// R15 - The at-or-above-low condition fires when the result is at or above the low limit.
// R16 - The below-low condition fires when the result is strictly below the low limit.
// R17 - Several satisfied conditions on one result make a single event.
module adc_ctrl
(
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic [`ADDR_W-1:0]      addr,
  input  wire logic [`DATA_W-1:0]      wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [`DATA_W-1:0]      rdata,
  input  wire logic                    device_idle,
  input  wire logic                    result_valid,
  input  wire logic [`CMP_INPUT_W-1:0] result_input,
  input  wire logic [`RESULT_W-1:0]    conversion_result,
  output logic                         converter_run,
  output logic      [`NUM_INPUTS-1:0]  level_trigger_select,
  output logic                         irq
);

  adc_ctrl_pkg::state_type state;
  adc_ctrl_pkg::state_type next_state;
  logic                    idle_sync;
  wire logic [1:0]         cond_hit;
  wire logic [`DATA_W-1:0] ctrl_word [2];

  // Idle comes from the power controller, another domain
  two_flop_sync i_two_flop_sync
  (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in (device_idle),
    .sync_out (idle_sync)
  );

  // One limit checker and one control word per comparator
  for (genvar g = 0; g < 2; g++)
  begin : gen_cmp  // R7
    limit_compare
    #(
      .WIDTH (`RESULT_W)
    )
    i_limit_compare
    (
      .cond_enable (state.cmp[g].cond_enable),
      .result      (conversion_result),
      .low_limit   (state.cmp[g].low_limit),
      .high_limit  (state.cmp[g].high_limit),
      .match       (cond_hit[g])
    );

    cmp_ctrl_word i_cmp_ctrl_word
    (
      .cmp  (state.cmp[g]),
      .word (ctrl_word[g])
    );
  end

  always_comb
  begin
    logic [`CMP_INPUT_W-1:0] idx;
    logic [`IRQ_W-1:0]       irq_set;
    logic                    result_counts;
    next_state = state;
    idx        = 5'h00;
    irq_set    = 2'h0;
    next_state.read_data = 16'h0000;
    // A stopped converter delivers nothing worth comparing
    result_counts = result_valid && converter_run;  // R1 R3

    // Register reads; flag clear happens before the event update so set wins
    if (rd)
    begin
      case (addr)
        `OFS_CONV_CTRL_LOW:
        begin
          next_state.read_data = {state.converter_on, 1'b0, state.halt_in_idle,
                                  13'h0000};  // R4
        end
        `OFS_TRIG_LOW:
        begin
          next_state.read_data = state.level_trigger_select[15:0];  // R5
        end
        `OFS_TRIG_HIGH:
        begin
          next_state.read_data = {10'h000, state.level_trigger_select[21:16]};  // R6
        end
        `OFS_CMP0_CTRL:
        begin
          next_state.read_data = ctrl_word[0];  // R8
          next_state.cmp[0].event_flag = 1'b0;  // R11
        end
        `OFS_CMP0_LOW:
        begin
          next_state.read_data = {4'h0, state.cmp[0].low_limit};
        end
        `OFS_CMP0_HIGH:
        begin
          next_state.read_data = {4'h0, state.cmp[0].high_limit};
        end
        `OFS_CMP1_CTRL:
        begin
          next_state.read_data = ctrl_word[1];  // R8
          next_state.cmp[1].event_flag = 1'b0;  // R11
        end
        `OFS_CMP1_LOW:
        begin
          next_state.read_data = {4'h0, state.cmp[1].low_limit};
        end
        `OFS_CMP1_HIGH:
        begin
          next_state.read_data = {4'h0, state.cmp[1].high_limit};
        end
        `OFS_IRQ_STATUS:
        begin
          next_state.read_data = {14'h0000, state.irq_status};
        end
        `OFS_IRQ_MASK:
        begin
          next_state.read_data = {14'h0000, state.irq_mask};
        end
        default:
        begin
          next_state.read_data = 16'h0000;
        end
      endcase
    end

    if (wr)
    begin
      case (addr)
        `OFS_CONV_CTRL_LOW:
        begin
          // Reserved bits 6-3 are not stored; software keeps them zero
          next_state.converter_on = wdata[`BIT_CONVERTER_ON];  // R1
          next_state.halt_in_idle = wdata[`BIT_HALT_IN_IDLE];  // R3
        end
        `OFS_TRIG_LOW:
        begin
          next_state.level_trigger_select[15:0] = wdata;  // R5
        end
        `OFS_TRIG_HIGH:
        begin
          next_state.level_trigger_select[21:16] = wdata[5:0];  // R6
        end
        `OFS_CMP0_CTRL:
        begin
          next_state.cmp[0].compare_unit_on    = wdata[`BIT_COMPARE_ON];
          next_state.cmp[0].interrupt_on_event = wdata[`BIT_IRQ_ON_EVENT];
          next_state.cmp[0].cond_enable        = wdata[`CMP_COND_W-1:0];
          if (!wdata[`BIT_COMPARE_ON])
            next_state.cmp[0].event_flag = 1'b0;  // R9
        end
        `OFS_CMP0_LOW:
        begin
          next_state.cmp[0].low_limit = wdata[`RESULT_W-1:0];
        end
        `OFS_CMP0_HIGH:
        begin
          next_state.cmp[0].high_limit = wdata[`RESULT_W-1:0];
        end
        `OFS_CMP1_CTRL:
        begin
          next_state.cmp[1].compare_unit_on    = wdata[`BIT_COMPARE_ON];
          next_state.cmp[1].interrupt_on_event = wdata[`BIT_IRQ_ON_EVENT];
          next_state.cmp[1].cond_enable        = wdata[`CMP_COND_W-1:0];
          if (!wdata[`BIT_COMPARE_ON])
            next_state.cmp[1].event_flag = 1'b0;  // R9
        end
        `OFS_CMP1_LOW:
        begin
          next_state.cmp[1].low_limit = wdata[`RESULT_W-1:0];
        end
        `OFS_CMP1_HIGH:
        begin
          next_state.cmp[1].high_limit = wdata[`RESULT_W-1:0];
        end
        `OFS_IRQ_STATUS:
        begin
          // Write one to clear; a same-cycle event sets it again below
          next_state.irq_status = state.irq_status & ~wdata[`IRQ_W-1:0];
        end
        `OFS_IRQ_MASK:
        begin
          next_state.irq_mask = wdata[`IRQ_W-1:0];
        end
        default:
        begin
        end
      endcase
    end

    // Comparison of each delivered result
    idx = result_input;
    for (int i = 0; i < 2; i++)
    begin
      if (result_counts && state.cmp[i].compare_unit_on)  // R9
      begin
        if (cond_hit[i])
        begin
          next_state.cmp[i].event_flag         = 1'b1;  // R11
          next_state.cmp[i].event_input_number = idx;  // R8
          if (state.cmp[i].interrupt_on_event)
            irq_set[i] = 1'b1;  // R10
        end
      end
    end
    // Set wins over a clear in the same cycle
    next_state.irq_status = next_state.irq_status | irq_set;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs come from state, and converter_run also from idle_sync; irq is a level, not a pulse
  assign converter_run        = state.converter_on && !(state.halt_in_idle && idle_sync);  // R1 R3
  assign level_trigger_select = state.level_trigger_select;  // R5 R6
  assign rdata                = state.read_data;
  assign irq                  = |(state.irq_status & state.irq_mask);  // R10

endmodule : adc_ctrl

// Two-flop synchroniser for a level from another clock domain
// Only the second flop is read; the first may still be settling
module two_flop_sync
#(
  parameter logic RESET_VALUE = 1'b0
)
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta;
  logic hold;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= RESET_VALUE;
      hold <= RESET_VALUE;
    end
    else
    begin
      meta <= async_in;
      hold <= meta;
    end
  end

  assign sync_out = hold;

endmodule : two_flop_sync

// Tests one result against one comparator's limits and enabled conditions
// Pure combinational; the caller decides whether the result counts at all
module limit_compare
#(
  parameter int WIDTH = `RESULT_W
)
(
  input  wire logic [`CMP_COND_W-1:0] cond_enable,
  input  wire logic [WIDTH-1:0]       result,
  input  wire logic [WIDTH-1:0]       low_limit,
  input  wire logic [WIDTH-1:0]       high_limit,
  output logic                        match
);

  logic                   below_low;
  logic                   below_high;
  logic                   at_or_above_low;
  logic                   at_or_above_high;
  logic                   in_window;
  logic [`CMP_COND_W-1:0] cond_met;

  // Unsigned compares; a low limit at or above the high limit empties the window
  assign below_low        = result < low_limit;
  assign below_high       = result < high_limit;
  assign at_or_above_low  = !below_low;
  assign at_or_above_high = !below_high;
  assign in_window        = at_or_above_low && below_high;

  assign cond_met[4] = cond_enable[4] && in_window;  // R12
  assign cond_met[3] = cond_enable[3] && at_or_above_high;  // R13
  assign cond_met[2] = cond_enable[2] && below_high;  // R14
  assign cond_met[1] = cond_enable[1] && at_or_above_low;  // R15
  assign cond_met[0] = cond_enable[0] && below_low;  // R16

  // Several met conditions still make one event
  assign match = |cond_met;  // R17

endmodule : limit_compare

// Packs one comparator's state into its control register layout
// Bits 15-13 are unimplemented and read zero
// Clearing the flag on a read is left to the register logic
module cmp_ctrl_word
(
  input  wire adc_ctrl_pkg::comparator_type cmp,
  output logic [`DATA_W-1:0]                word
);

  assign word[15:13] = 3'h0;
  assign word[12:8]  = cmp.event_input_number;  // R8
  assign word[7]     = cmp.compare_unit_on;  // R9
  assign word[6]     = cmp.interrupt_on_event;  // R10
  assign word[5]     = cmp.event_flag;  // R11
  assign word[4:0]   = cmp.cond_enable;

endmodule : cmp_ctrl_word

/* File: verif/adc_ctrl_props.sv */
// Purpose: Port-level assertions of the converter control block
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Comparator state is checked by the bench
`timescale 1ns/1ns
`include "adc_ctrl_cfg.svh"
module adc_ctrl_props
(
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire logic [`ADDR_W-1:0]     addr,
  input wire logic [`DATA_W-1:0]     wdata,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire logic [`DATA_W-1:0]     rdata,
  input wire logic                   device_idle,
  input wire logic                   result_valid,
  input wire logic                   converter_run,
  input wire logic [`NUM_INPUTS-1:0] level_trigger_select,
  input wire logic                   irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_CTRL_LOW_RSVD: assert property (rd && addr == 4'h0 |=> (rdata & 16'h5fff) == 16'h0)
    else $error("reserved control bits read nonzero");
  AST_TRIG_HI_RSVD: assert property (rd && addr == 4'h2 |=> rdata[15:6] == 10'h0)
    else $error("upper trigger bits read nonzero");
  AST_CMP_RSVD: assert property (rd && addr == 4'h3 |=> rdata[15:13] == 3'h0)
    else $error("comparator upper bits read nonzero");
  AST_RUN_OFF: assert property (wr && addr == 4'h0 && !wdata[15] |=> !converter_run)
    else $error("converter runs while off");
  AST_RUN_ON: assert property (wr && addr == 4'h0 && wdata[15] && !wdata[13] |=> converter_run)
    else $error("converter not running");
  // Two sync flops, so the third idle cycle must show the stop
  AST_IDLE_STOP: assert property ((wr && addr == 4'h0 && wdata[15] && wdata[13])
    ##2 (!wr && device_idle) [*3] |-> !converter_run) else $error("no stop in idle");
  AST_TRIG_LO: assert property (wr && addr == 4'h1 |=> level_trigger_select[15:0] == $past(wdata))
    else $error("low trigger select mismatch");
  AST_TRIG_HI: assert property (wr && addr == 4'h2 |=> level_trigger_select[21:16] == $past(wdata[5:0]))
    else $error("high trigger select mismatch");
  AST_IRQ_CLR: assert property (wr && addr == 4'h9 && wdata[1:0] == 2'h3 && !result_valid |=> !irq)
    else $error("interrupt survives clear");
  AST_IRQ_CAUSE: assert property (!irq && !result_valid && !(wr && addr == 4'ha) |=> !irq)
    else $error("interrupt without cause");
  cover property (irq);
  cover property (device_idle && !converter_run);
  cover property (rd && addr == 4'h3 ##1 rdata[5]);
endmodule : adc_ctrl_props
bind adc_ctrl adc_ctrl_props i_adc_ctrl_props (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
  .device_idle, .result_valid, .converter_run, .level_trigger_select, .irq);

/* File: verif/tb_top.sv */
// Purpose: Random and corner tests of the converter control block
// Assumes: Register map of adc_ctrl_cfg.svh
// Notes:   Expected values come from bench functions
`timescale 1ns/1ns
module tb_top;
  logic        clk = 0, arst_n = 0, wr = 0, rd = 0, device_idle = 0, result_valid = 0;
  logic [3:0]  addr = 0;
  logic [15:0] wdata = 0, rdata;
  logic [4:0]  result_input = 0;
  logic [11:0] conversion_result = 0;
  logic        converter_run, irq;
  logic [21:0] level_trigger_select;
  int          err_count = 0, comparisons = 0;
  always #2 clk = ~clk;
  adc_ctrl i_adc_ctrl (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .device_idle,
    .result_valid, .result_input, .conversion_result, .converter_run, .level_trigger_select, .irq);
  task automatic close_out;
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_chk
  task automatic send(input logic [4:0] ch, input logic [11:0] r);
    @(posedge clk);
    result_valid <= 1'b1;
    result_input <= ch;
    conversion_result <= r;
    @(posedge clk);
    result_valid <= 1'b0;
  endtask : send
  function automatic logic hit(logic [4:0] c, logic [11:0] r, lo, hi);
    return (c[4] && r >= lo && r < hi) || (c[3] && r >= hi) || (c[2] && r < hi)
      || (c[1] && r >= lo) || (c[0] && r < lo);
  endfunction : hit
  initial
  begin
    #200000;
    err_count++;
    close_out;
  end
  initial
  begin
    logic [15:0] v;
    logic [11:0] lo, hi, r;
    logic [4:0]  c, ch;
    logic [4:0]  num [2];
    logic        ie, ev;
    num = '{default: 5'h0};
    void'($urandom(32'he87063c7));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 16; a++)
      rd_chk(4'(a), 16'h0000);
    wr_reg(4'h0, 16'hff87);
    device_idle <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(16'(converter_run), 16'h0);
    rd_chk(4'h0, 16'ha000);
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h2, 16'hffff);
    rd_chk(4'h2, 16'h003f);
    v = 16'($urandom);
    wr_reg(4'h1, v);
    rd_chk(4'h1, v);
    chk(level_trigger_select[15:0], v);
    chk(16'(level_trigger_select[21:16]), 16'h3f);
    wr_reg(4'h0, 16'h8000);
    #1 chk(16'(converter_run), 16'h1);
    wr_reg(4'ha, 16'h0003);
    for (int n = 0; n < 40; n++)
    begin
      int i;
      i = n % 2;
      c = (n < 10) ? 5'h1 << (n / 2) : 5'($urandom);
      ie = 1'($urandom);
      ch = 5'($urandom % 22);
      lo = 12'($urandom % 2000 + 1);
      hi = lo + 12'($urandom % 2000 + 1);
      r = (n[1] ? hi : lo) + 12'($urandom % 3) - 12'h1;
      wr_reg(4'h0, 16'h0000);
      wr_reg(4'(4 + 3 * i), {4'h0, lo});
      wr_reg(4'(5 + 3 * i), {4'h0, hi});
      wr_reg(4'(3 + 3 * i), {8'h0, 1'b1, ie, 1'b0, c});
      wr_reg(4'h0, 16'h8000);
      send(ch, r);
      ev = hit(c, r, lo, hi);
      if (ev)
        num[i] = ch;
      #1 chk(16'(irq), 16'(ev & ie));
      rd_chk(4'h9, 16'(ev & ie) << i);
      rd_chk(4'(3 + 3 * i), {3'h0, num[i], 1'b1, ie, ev, c});
      rd_chk(4'(3 + 3 * i), {3'h0, num[i], 1'b1, ie, 1'b0, c});
      wr_reg(4'(3 + 3 * i), 16'h0000);
      wr_reg(4'h9, 16'h0003);
    end
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h4, 16'h0000);
    wr_reg(4'h5, 16'h0fff);
    wr_reg(4'h3, 16'h00c4);
    wr_reg(4'h0, 16'h8000);
    send(5'd21, 12'h001);
    wr_reg(4'h3, 16'h0044);
    rd_chk(4'h3, 16'h1544);
    wr_reg(4'ha, 16'h0000);
    #1 chk(16'(irq), 16'h0);
    rd_chk(4'h9, 16'h0001);
    wr_reg(4'h9, 16'h0001);
    send(5'd3, 12'h001);
    rd_chk(4'h9, 16'h0000);
    wr_reg(4'h3, 16'h00c4);
    wr_reg(4'h0, 16'h0000);
    #1 chk(16'(converter_run), 16'h0);
    send(5'd3, 12'h001);
    rd_chk(4'h3, 16'h15c4);
    close_out;
  end
endmodule : tb_top
